/* File: sra_host_model.sv */
// Serial master model standing in for the host
`timescale 1ns/100ps
module sra_host_model (
    // Clock for alignment
    input wire logic sys_clk,
    // Serial pins
    output logic sck,
    output logic mosi,
    output logic slave_select_n,
    input wire logic miso_w
);
    logic [15:0] tx [0:3];
    logic [15:0] rx [0:3];
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        slave_select_n = 1'b1;
        // Known words so unused data slots never put unknowns on the line
        for (int i = 0; i < 4; i++) begin
            tx[i] = 16'h0000;
            rx[i] = 16'h0000;
        end
    end
    // Callers keep every multi-word access inside one block
    // Words to send, bits in the last word, long gap for standard format
    task automatic frame(input int nw, input int lastb, input bit std);
        @(negedge sys_clk);
        slave_select_n = 1'b0;
        #300;
        for (int w = 0; w < nw; w++) begin
            for (int b = 15; b >= 16 - ((w == nw - 1) ? lastb : 16); b--) begin
                mosi = tx[w][b];
                #80 sck = 1'b1;
                rx[w][b] = miso_w;
                #80 sck = 1'b0;
            end
            #((w == 0 && std) ? 5200 : 300);
        end
        slave_select_n = 1'b1;
        // Released line must not keep its last value
        mosi = ~mosi;
        #1000;
    endtask
endmodule // sra_host_model

/* File: sra_link_if.sv */
// Synchronised pin levels and edges passed from the sampler to the core
`timescale 1ns/100ps
interface sra_link_if #(parameter int W = 3);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport sampler (output level, output rise, output fall);
    modport core (input level, input rise, input fall);
endinterface

/* File: sra_pin_sampler.sv */
// Three-stage pin synchroniser with agreement filter and edge finder
`timescale 1ns/100ps
module sra_pin_sampler
    import sra_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] IDLE_LEVEL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Raw pins
    input wire logic [W-1:0] pins,
    // Synchronised view
    sra_link_if.sampler link
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } sra_samp_type;

    sra_samp_type s_q;
    sra_samp_type s_d;
    logic [W-1:0] agree;

    // A change counts only once stages two and three agree
    always_comb begin
        s_d = s_q;
        agree = ~(s_q.s2 ^ s_q.s3);
        s_d.s1 = pins;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.lvl = (agree & s_q.s3) | (~agree & s_q.lvl);
        s_d.rise = agree & s_q.s3 & ~s_q.lvl;
        s_d.fall = agree & ~s_q.s3 & s_q.lvl;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= '{s1: IDLE_LEVEL, s2: IDLE_LEVEL, s3: IDLE_LEVEL, lvl: IDLE_LEVEL,
                     rise: '0, fall: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.level = s_q.lvl;
    assign link.rise = s_q.rise;
    assign link.fall = s_q.fall;

endmodule // sra_pin_sampler

/* File: sra_pkg.sv */
// Shared constants and types for the serial register access slave
package sra_pkg;

    localparam int SRA_WORD_W = 16;
    localparam int SRA_ADDR_W = 12;
    localparam int SRA_CODE_W = 4;
    localparam int SRA_BIT_CNT_W = 4;

    // Synchronised pin lanes
    localparam int SRA_PIN_W = 3;
    localparam int SRA_PIN_SCK = 0;
    localparam int SRA_PIN_MOSI = 1;
    localparam int SRA_PIN_SEL_N = 2;
    localparam logic [2:0] SRA_PIN_IDLE = 3'h4;

    // Access codes
    localparam logic [3:0] SRA_READ_NEXT_STANDARD = 4'h0;
    localparam logic [3:0] SRA_READ_THEN_BURST = 4'h1;
    localparam logic [3:0] SRA_WRITE_READ_THEN_BURST = 4'hE;
    localparam logic [3:0] SRA_WRITE_READ_THEN_STANDARD = 4'hF;

    // Identifier register
    localparam logic [15:0] SRA_ID_RESET = 16'hABCD;
    localparam logic [11:0] SRA_ID_ADDR_DEFAULT = 12'h000;
    localparam logic [3:0] SRA_LAST_BIT = 4'hF;

    typedef enum logic [1:0] {
        SRA_IDLE = 2'b00,
        SRA_HEAD = 2'b01,
        SRA_DATA = 2'b10
    } sra_phase_type;

endpackage

/* File: sra_spi_slave.sv */
// Serial register access slave: framing, access codes, formats and word engine
`timescale 1ns/100ps

// Notes on behaviour
// [RULE1] Device is only a slave; host drives select low and supplies the clock.
// [RULE2] MOSI sampled on rising clock, MISO changes on falling clock, mode 0.
// [RULE3] Host frames each transaction with select; select tied low is unsupported.
// [RULE4] Registers are 16 bits wide, each selected by a 12-bit address.
// [RULE5] Host opens with a 4-bit access code then a 12-bit address.
// [RULE6] Code 0 read/std, 1 read/burst, E write-read/burst, F write-read/std.
// [RULE7] Standard read shifts the addressed word out after the address, ignoring MOSI.
// [RULE8] Write-read stores the incoming word and returns the prior contents.
// [RULE9] Standard format host waits a gap after the address before data.
// [RULE10] That gap is at least 5 us, or 7 us with repeat measuring on.
// [RULE11] Standard transactions send the identifier word first; resets to ABCD, writable.
// [RULE12] Host should check the returned identifier to verify the link.
// [RULE13] Writes to unimplemented addresses are discarded; MISO then undefined.
// [RULE14] Extra words access successive registers with an incrementing address.
// [RULE15] Host keeps a multi-word access inside one block of upper address bits.
// [RULE16] A partial word left when select rises is discarded.
// [RULE17] Host leaves an inter-word gap between last and first rising clocks.
// [RULE18] Inter-word gap is at least 250 ns.
// [RULE19] Burst reads start at the previous address; writes use the current one.
// [RULE20] Burst format sends register data from the first word, no identifier.
// [RULE21] Burst needs no address gap; buffer is preloaded between transactions.
// [RULE22] Burst only follows codes 1 or E; otherwise standard format.
// [RULE23] Burst write-read returns one more register word than is written.
// [RULE24] Burst supports a single-word read returning the previously addressed register.
// [RULE25] After reset the first transaction uses standard format.
module sra_spi_slave
    import sra_pkg::*;
#(
    parameter logic [11:0] ID_ADDR = SRA_ID_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic slave_select_n,
    output logic miso,
    output logic miso_oe,
    // Register read channel
    output logic reg_rd_req,
    output logic [11:0] reg_rd_addr,
    input wire logic reg_rd_ack,
    input wire logic [15:0] reg_rd_data,
    // Register write channel
    output logic [11:0] reg_wr_addr,
    output logic [15:0] reg_wr_data,
    input wire logic reg_addr_ok,
    output logic reg_wr_en
);

    typedef struct packed {
        sra_phase_type phase;
        logic [3:0] bit_cnt;
        logic [15:0] sh_in;
        logic [15:0] sh_out;
        logic [3:0] code;
        logic [11:0] head_addr;
        logic [11:0] wa;
        logic [15:0] wd;
        logic wr_stb;
        logic [11:0] rd_ptr;
        logic [11:0] prev_addr;
        logic burst_next;
        logic burst_cur;
        logic write_mode;
        logic boundary;
        logic load_pend;
        logic [15:0] tx_buf;
        logic tx_valid;
        logic rd_pend;
        logic [11:0] rd_addr;
        logic pre_want;
        logic [15:0] id;
    } sra_core_type;

    sra_core_type s_q;
    sra_core_type s_d;
    logic [15:0] word_in;
    logic [3:0] hcode;

    sra_link_if #(.W(SRA_PIN_W)) link ();

    // [RULE1] Host-driven pins
    sra_pin_sampler #(
        .W(SRA_PIN_W),
        .IDLE_LEVEL(SRA_PIN_IDLE)
    ) u_sampler (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pins({slave_select_n, mosi, sck}),
        .link(link.sampler)
    );

    always_comb begin
        s_d = s_q;
        s_d.wr_stb = 1'b0;
        word_in = {s_q.sh_in[14:0], link.level[SRA_PIN_MOSI]};
        hcode = word_in[15:12];

        // Fetch answers; identifier lives here, the rest comes from outside
        if (s_q.rd_pend && s_q.rd_addr == ID_ADDR) begin
            s_d.rd_pend = 1'b0;
            s_d.tx_buf = s_q.id;
            s_d.tx_valid = 1'b1;
        end else if (s_q.rd_pend && reg_rd_ack) begin
            s_d.rd_pend = 1'b0;
            s_d.tx_buf = reg_rd_data;
            s_d.tx_valid = 1'b1;
        end

        // [RULE14] Next address steps after each write
        if (s_q.wr_stb) begin
            s_d.wa = s_q.wa + 12'h001;
        end

        // [RULE21] Preload between transactions, once the channel is free
        // [RULE24] Single-word burst read served from this preload
        if (s_q.pre_want && !s_d.rd_pend && s_q.phase == SRA_IDLE) begin
            s_d.pre_want = 1'b0;
            s_d.rd_pend = 1'b1;
            s_d.rd_addr = s_q.prev_addr;
            s_d.rd_ptr = s_q.prev_addr + 12'h001;
            s_d.tx_valid = 1'b0;
        end

        if (link.fall[SRA_PIN_SEL_N]) begin
            // [RULE22] Format chosen by the previous access code
            s_d.phase = SRA_HEAD;
            s_d.bit_cnt = '0;
            s_d.boundary = 1'b0;
            s_d.load_pend = 1'b0;
            s_d.burst_cur = s_q.burst_next;
            if (!s_q.burst_next) begin
                // [RULE11] Identifier word first
                s_d.sh_out = s_q.id;
            end else if (s_d.tx_valid) begin
                // [RULE20] Preloaded data goes out first
                s_d.sh_out = s_d.tx_buf;
                s_d.tx_valid = 1'b0;
            end else begin
                s_d.load_pend = 1'b1;
            end
        end else if (link.rise[SRA_PIN_SEL_N] && s_q.phase != SRA_IDLE) begin
            // [RULE16] Partial word dropped, nothing written
            s_d.phase = SRA_IDLE;
            s_d.bit_cnt = '0;
            s_d.boundary = 1'b0;
            s_d.load_pend = 1'b0;
            s_d.tx_valid = 1'b0;
            // Idle line reads low until the next frame loads a word
            s_d.sh_out = '0;
            if (s_q.phase == SRA_DATA) begin
                // [RULE6] Code picks the next format
                unique case (s_q.code)
                    SRA_READ_THEN_BURST,
                    SRA_WRITE_READ_THEN_BURST: begin
                        s_d.burst_next = 1'b1;
                    end
                    SRA_READ_NEXT_STANDARD,
                    SRA_WRITE_READ_THEN_STANDARD: begin
                        s_d.burst_next = 1'b0;
                    end
                    default: begin
                        // Reserved codes fall back to standard format
                        s_d.burst_next = 1'b0;
                    end
                endcase
                s_d.prev_addr = s_q.head_addr;
            end
            s_d.pre_want = s_d.burst_next;
        end else if (s_q.phase != SRA_IDLE) begin
            // [RULE2] Sample on rising clock
            if (link.rise[SRA_PIN_SCK]) begin
                s_d.sh_in = word_in;
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                if (s_q.bit_cnt == SRA_LAST_BIT) begin
                    s_d.boundary = 1'b1;
                    s_d.rd_pend = 1'b1;
                    s_d.tx_valid = 1'b0;
                    if (s_q.phase == SRA_HEAD) begin
                        // [RULE5] Code then address
                        s_d.phase = SRA_DATA;
                        s_d.code = hcode;
                        s_d.head_addr = word_in[11:0];
                        s_d.wa = word_in[11:0];
                        // [RULE8] Write-read codes
                        unique case (hcode)
                            SRA_WRITE_READ_THEN_BURST,
                            SRA_WRITE_READ_THEN_STANDARD: begin
                                s_d.write_mode = 1'b1;
                            end
                            SRA_READ_NEXT_STANDARD,
                            SRA_READ_THEN_BURST: begin
                                s_d.write_mode = 1'b0;
                            end
                            default: begin
                                // Reserved codes are served as plain reads
                                s_d.write_mode = 1'b0;
                            end
                        endcase
                        if (s_q.burst_cur) begin
                            // [RULE19] Reads continue from the previous address
                            s_d.rd_addr = s_q.rd_ptr;
                            s_d.rd_ptr = s_q.rd_ptr + 12'h001;
                        end else begin
                            // [RULE7] Standard read of the given address
                            s_d.rd_addr = word_in[11:0];
                            s_d.rd_ptr = word_in[11:0] + 12'h001;
                        end
                    end else begin
                        // [RULE14] Next register per word
                        s_d.rd_addr = s_q.rd_ptr;
                        s_d.rd_ptr = s_q.rd_ptr + 12'h001;
                        if (s_q.write_mode) begin
                            // [RULE23] Write lags the read by one word in burst
                            s_d.wd = word_in;
                            // Strobe also steps the address past the identifier
                            s_d.wr_stb = 1'b1;
                            if (s_q.wa == ID_ADDR) begin
                                s_d.id = word_in;
                            end
                        end
                    end
                end
            end

            // [RULE2] Change MISO on falling clock
            if (link.fall[SRA_PIN_SCK]) begin
                if (s_q.boundary) begin
                    s_d.boundary = 1'b0;
                    if (s_d.tx_valid) begin
                        s_d.sh_out = s_d.tx_buf;
                        s_d.tx_valid = 1'b0;
                    end else begin
                        s_d.load_pend = 1'b1;
                    end
                end else begin
                    s_d.sh_out = {s_q.sh_out[14:0], 1'b0};
                end
            end else if (s_q.load_pend && s_d.tx_valid) begin
                // [RULE9] Late fetch is placed during the host's gap
                s_d.sh_out = s_d.tx_buf;
                s_d.tx_valid = 1'b0;
                s_d.load_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= '0;
            // [RULE11] Identifier reset value
            s_q.id <= SRA_ID_RESET;
            // [RULE25] First transaction is standard
            s_q.burst_next <= 1'b0;
            s_q.phase <= SRA_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // [RULE4] Word and address widths on the register side
    assign reg_rd_req = s_q.rd_pend && (s_q.rd_addr != ID_ADDR);
    assign reg_rd_addr = s_q.rd_addr;
    assign reg_wr_addr = s_q.wa;
    assign reg_wr_data = s_q.wd;
    // [RULE13] Unimplemented addresses take no write
    assign reg_wr_en = s_q.wr_stb && reg_addr_ok && (s_q.wa != ID_ADDR);

    assign miso = s_q.sh_out[15];
    assign miso_oe = (s_q.phase != SRA_IDLE);

endmodule // sra_spi_slave

/* File: sra_spi_slave_chk.sv */
// Port checks for the serial register access slave
`timescale 1ns/100ps
module sra_spi_slave_chk
    import sra_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic slave_select_n,
    input wire logic miso,
    input wire logic miso_oe,
    // Register channels
    input wire logic reg_rd_req,
    input wire logic [11:0] reg_rd_addr,
    input wire logic reg_rd_ack,
    input wire logic [15:0] reg_rd_data,
    input wire logic [11:0] reg_wr_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_addr_ok,
    input wire logic reg_wr_en
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !miso_oe && !miso && !reg_rd_req && !reg_wr_en)
        else $error("outputs not quiet in reset");
    a_oe_opens: assert property ($fell(slave_select_n) |-> ##[1:8] miso_oe)
        else $error("miso_oe late after select");
    a_oe_closes: assert property (slave_select_n [*8] |-> !miso_oe)
        else $error("miso_oe held after select rise");
    a_miso_idle: assert property (!miso_oe |-> !miso)
        else $error("miso active while idle");
    a_req_holds: assert property (reg_rd_req && !reg_rd_ack |=>
        reg_rd_req && $stable(reg_rd_addr))
        else $error("read request dropped early");
    a_req_ends: assert property (reg_rd_ack |=> !reg_rd_req)
        else $error("read request after ack");
    a_wr_decode: assert property (reg_wr_en |-> reg_addr_ok)
        else $error("write to unimplemented address");
    a_wr_step: assert property (reg_wr_en |=>
        !reg_wr_en && reg_wr_addr == $past(reg_wr_addr) + 12'h001)
        else $error("write address not stepped");
    a_wr_framed: assert property (slave_select_n [*8] |-> !reg_wr_en)
        else $error("write outside a frame");

    c_write: cover property (reg_wr_en);
    c_read: cover property (reg_rd_ack ##1 !reg_rd_req);
    c_close: cover property ($fell(miso_oe));
endmodule // sra_spi_slave_chk

bind sra_spi_slave sra_spi_slave_chk i_sra_spi_slave_chk (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .sck(sck), .mosi(mosi), .slave_select_n(slave_select_n),
    .miso(miso), .miso_oe(miso_oe), .reg_rd_req(reg_rd_req), .reg_rd_addr(reg_rd_addr),
    .reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_addr_ok(reg_addr_ok), .reg_wr_en(reg_wr_en));

/* File: tb_sra_spi_slave.sv */
// Testbench for the serial register access slave
`timescale 1ns/100ps
module tb_sra_spi_slave
    import sra_pkg::*;
;
    logic sys_clk, sys_rst, sck, mosi, slave_select_n, miso, miso_oe, miso_w;
    logic reg_rd_req, reg_addr_ok, reg_wr_en;
    logic reg_rd_ack = 1'b0;
    logic [11:0] reg_rd_addr, reg_wr_addr;
    logic [15:0] reg_wr_data, id_e;
    logic [15:0] reg_rd_data = 16'h0000;
    logic [15:0] mem [0:4095];
    int bad_count, n_compared;
    int wait_c = 0;
    assign miso_w = miso_oe ? miso : 1'b1;
    // Upper half of the map is unimplemented
    assign reg_addr_ok = reg_wr_addr < 12'h800;
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    sra_spi_slave i_sra_spi_slave (.sys_clk(sys_clk), .sys_rst(sys_rst), .sck(sck),
        .mosi(mosi), .slave_select_n(slave_select_n), .miso(miso), .miso_oe(miso_oe),
        .reg_rd_req(reg_rd_req), .reg_rd_addr(reg_rd_addr), .reg_rd_ack(reg_rd_ack),
        .reg_rd_data(reg_rd_data), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_addr_ok(reg_addr_ok), .reg_wr_en(reg_wr_en));
    sra_host_model i_sra_host_model (.sys_clk(sys_clk), .sck(sck), .mosi(mosi),
        .slave_select_n(slave_select_n), .miso_w(miso_w));
    // Register store answers reads after a short wait
    always @(posedge sys_clk) begin
        reg_rd_ack <= 1'b0;
        if (reg_rd_req && !reg_rd_ack) wait_c <= wait_c + 1;
        if (wait_c == 2) begin
            reg_rd_ack <= 1'b1;
            reg_rd_data <= mem[reg_rd_addr];
            wait_c <= 0;
        end
        if (reg_wr_en) mem[reg_wr_addr] <= reg_wr_data;
    end
    function automatic logic [15:0] mem_e(input logic [11:0] a);
        return {4'h5, a};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [11:0] a, input int nw, input int lb,
        input bit std);
        i_sra_host_model.tx[0] = {c, a};
        i_sra_host_model.frame(nw, lb, std);
    endtask
    task automatic t_std_read;
        go(SRA_READ_NEXT_STANDARD, 12'h010, 3, 16, 1);
        chk(i_sra_host_model.rx[0], id_e);
        chk(i_sra_host_model.rx[1], mem_e(12'h010));
        chk(i_sra_host_model.rx[2], mem_e(12'h011));
    endtask
    task automatic t_write_read;
        i_sra_host_model.tx[1] = 16'h1234;
        i_sra_host_model.tx[2] = 16'h5678;
        go(SRA_WRITE_READ_THEN_STANDARD, 12'h030, 3, 16, 1);
        chk(i_sra_host_model.rx[1], mem_e(12'h030));
        chk(i_sra_host_model.rx[2], mem_e(12'h031));
        chk(mem[12'h030], 16'h1234);
        chk(mem[12'h031], 16'h5678);
        i_sra_host_model.tx[1] = 16'h2468;
        go(SRA_WRITE_READ_THEN_STANDARD, SRA_ID_ADDR_DEFAULT, 2, 16, 1);
        chk(i_sra_host_model.rx[1], id_e);
        chk(mem[SRA_ID_ADDR_DEFAULT], mem_e(SRA_ID_ADDR_DEFAULT));
        id_e = 16'h2468;
    endtask
    task automatic t_burst;
        go(SRA_READ_THEN_BURST, 12'h040, 1, 16, 1);
        chk(i_sra_host_model.rx[0], id_e);
        go(SRA_READ_THEN_BURST, 12'h050, 2, 16, 0);
        chk(i_sra_host_model.rx[0], mem_e(12'h040));
        chk(i_sra_host_model.rx[1], mem_e(12'h041));
        go(SRA_READ_NEXT_STANDARD, 12'h060, 1, 16, 0);
        chk(i_sra_host_model.rx[0], mem_e(12'h050));
        go(SRA_READ_NEXT_STANDARD, 12'h070, 2, 16, 1);
        chk(i_sra_host_model.rx[0], id_e);
        chk(i_sra_host_model.rx[1], mem_e(12'h070));
    endtask
    task automatic t_burst_write;
        i_sra_host_model.tx[1] = 16'h0F0F;
        go(SRA_WRITE_READ_THEN_BURST, 12'h080, 2, 16, 1);
        chk(i_sra_host_model.rx[1], mem_e(12'h080));
        i_sra_host_model.tx[1] = 16'hA5A5;
        go(SRA_WRITE_READ_THEN_STANDARD, 12'h090, 2, 16, 0);
        chk(i_sra_host_model.rx[0], 16'h0F0F);
        chk(i_sra_host_model.rx[1], mem_e(12'h081));
        chk(mem[12'h090], 16'hA5A5);
    endtask
    task automatic t_refused;
        i_sra_host_model.tx[1] = 16'h3333;
        go(SRA_WRITE_READ_THEN_STANDARD, 12'h900, 2, 16, 1);
        chk(mem[12'h900], mem_e(12'h900));
        go(SRA_WRITE_READ_THEN_STANDARD, 12'h0A0, 2, 8, 1);
        chk(mem[12'h0A0], mem_e(12'h0A0));
        // Reserved code acts as a read with the next frame standard
        go(4'h5, 12'h0B0, 1, 16, 1);
        go(SRA_READ_NEXT_STANDARD, 12'h0C0, 2, 16, 1);
        chk(i_sra_host_model.rx[0], id_e);
        chk(i_sra_host_model.rx[1], mem_e(12'h0C0));
    endtask
    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Run should end near 27300 cycles
    initial begin
        repeat (70000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        sys_rst = 1'b1;
        bad_count = 0;
        n_compared = 0;
        id_e = SRA_ID_RESET;
        for (int i = 0; i < 4096; i++) mem[i] = mem_e(12'(i));
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge sys_clk);
        t_std_read();
        t_write_read();
        t_burst();
        t_burst_write();
        t_refused();
        report_and_stop();
    end
endmodule // tb_sra_spi_slave
